/* File: src/gpt_pkg.sv */
/*
 holds register offsets, reset values and bus constants for the touch-shared gpio ports.
 assumes a 32-bit axi4-lite register bus and one 100 MHz clock.
*/
package gpt_pkg;
  localparam int gpt_aw = 5;
  localparam logic [gpt_aw-1:0] gpt_off_touch_data = 5'h00;
  localparam logic [gpt_aw-1:0] gpt_off_touch_dir = 5'h04;
  localparam logic [gpt_aw-1:0] gpt_off_touch_pull = 5'h08;
  localparam logic [gpt_aw-1:0] gpt_off_touch_dis = 5'h0c;
  localparam logic [gpt_aw-1:0] gpt_off_osc_data = 5'h10;
  localparam logic [gpt_aw-1:0] gpt_off_osc_dir = 5'h14;
  localparam logic [gpt_aw-1:0] gpt_off_standby = 5'h18;
  localparam logic [gpt_aw-1:0] gpt_off_status = 5'h1c;
  localparam int gpt_osc_w = 3;
  localparam logic [7:0] gpt_rst_byte = 8'h00;
  localparam logic [gpt_osc_w-1:0] gpt_rst_osc = 3'h0;
  localparam logic [gpt_osc_w-1:0] gpt_osc_open_drain = 3'h4;
  localparam int gpt_stby_float_bit = 0;
  localparam int gpt_stby_touch_run_bit = 1;
  localparam logic [1:0] gpt_resp_okay = 2'h0;
  localparam logic [1:0] gpt_resp_slverr = 2'h2;
endpackage

/* File: src/gpt_sync.sv */
/*
 holds a parameterised two-flop synchroniser for pin levels.
 assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
module gpt_sync #(
  parameter int width = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* File: src/gpt_port.sv */
/*
 holds the touch-shared 8-pin port, the 3-pin oscillator/reset port and their axi4-lite slave.
 assumes pins arrive asynchronously, standby entry comes as a level from the standby controller,
 and the cpu marks read-modify-write reads with a qualifier held with the read address.
*/
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module gpt_port
  import gpt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [gpt_aw-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpt_aw-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic read_modify_write,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standby_enter,
  input wire logic [7:0] touch_pin_in,
  output logic [7:0] touch_pin_out,
  output logic [7:0] touch_pin_oe_n,
  output logic [7:0] touch_pullup_on,
  output logic [7:0] touch_port_in_en,
  output logic [7:0] touch_sense_en,
  output logic [gpt_osc_w-1:0] osc_pin_in_dummy_unused_n,
  input wire logic [gpt_osc_w-1:0] osc_pin_in,
  output logic [gpt_osc_w-1:0] osc_pin_out,
  output logic [gpt_osc_w-1:0] osc_pin_oe_n
);
  logic [7:0] touch_port_data_latch;
  logic [7:0] touch_port_direction;
  logic [7:0] touch_port_pullup_enable;
  logic [7:0] touch_input_disable_upper;
  logic [gpt_osc_w-1:0] osc_port_data_latch;
  logic [gpt_osc_w-1:0] osc_port_direction;
  logic standby_pin_float;
  logic touch_run_in_stop;
  logic [7:0] touch_sync;
  logic [gpt_osc_w-1:0] osc_sync;
  logic standby_sync;
  logic [gpt_aw-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_held;
  logic w_held;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] next_rdata;
  logic rd_hit;
  logic float_now;
  logic [7:0] touch_in_blocked;
  logic [7:0] touch_pin_view;
  logic [gpt_osc_w-1:0] osc_pin_view;
  logic [7:0] next_touch_oe_n;
  logic [7:0] next_touch_out;
  logic [gpt_osc_w-1:0] next_osc_oe_n;
  logic wr_lane0;
  logic wr_touch_data;
  logic wr_touch_dir;
  logic wr_touch_pull;
  logic wr_touch_dis;
  logic wr_osc_data;
  logic wr_osc_dir;
  logic wr_standby;

  gpt_sync #(.width(8)) u_touch_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(touch_pin_in),
    .sync_out(touch_sync)
  );

  gpt_sync #(.width(gpt_osc_w + 1)) u_osc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({standby_enter, osc_pin_in}),
    .sync_out({standby_sync, osc_sync})
  );

  // write channel capture, address and data in either order
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_comb begin
    case (wr_addr)
      gpt_off_touch_data, gpt_off_touch_dir, gpt_off_touch_pull, gpt_off_touch_dis,
      gpt_off_osc_data, gpt_off_osc_dir, gpt_off_standby: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpt_resp_okay;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? gpt_resp_okay : gpt_resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only byte lane 0 carries register data
  assign wr_lane0 = wr_fire && wr_strb[0];
  assign wr_touch_data = wr_lane0 && (wr_addr == gpt_off_touch_data);
  assign wr_touch_dir = wr_lane0 && (wr_addr == gpt_off_touch_dir);
  assign wr_touch_pull = wr_lane0 && (wr_addr == gpt_off_touch_pull);
  assign wr_touch_dis = wr_lane0 && (wr_addr == gpt_off_touch_dis);
  assign wr_osc_data = wr_lane0 && (wr_addr == gpt_off_osc_data);
  assign wr_osc_dir = wr_lane0 && (wr_addr == gpt_off_osc_dir);
  assign wr_standby = wr_lane0 && (wr_addr == gpt_off_standby);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_port_data_latch <= gpt_rst_byte;
    end else if (wr_touch_data) begin
      touch_port_data_latch <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_port_direction <= gpt_rst_byte;
    end else if (wr_touch_dir) begin
      touch_port_direction <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_port_pullup_enable <= gpt_rst_byte;
    end else if (wr_touch_pull) begin
      touch_port_pullup_enable <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_input_disable_upper <= gpt_rst_byte;
    end else if (wr_touch_dis) begin
      touch_input_disable_upper <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_port_data_latch <= gpt_rst_osc;
    end else if (wr_osc_data) begin
      osc_port_data_latch <= wr_data[gpt_osc_w-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_port_direction <= gpt_rst_osc;
    end else if (wr_osc_dir) begin
      osc_port_direction <= wr_data[gpt_osc_w-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_pin_float <= 1'b0;
      touch_run_in_stop <= 1'b0;
    end else if (wr_standby) begin
      standby_pin_float <= wr_data[gpt_stby_float_bit];
      touch_run_in_stop <= wr_data[gpt_stby_touch_run_bit];
    end
  end

  // pin side control
  assign float_now = standby_sync && standby_pin_float;
  // touch input stays live in standby when touch run is set
  assign touch_in_blocked = float_now && !touch_run_in_stop ? 8'hff : 8'h00;
  // blocked inputs read low; port input needs its disable bit set
  assign touch_pin_view = touch_sync & ~touch_in_blocked & touch_input_disable_upper;
  assign osc_pin_view = float_now ? gpt_rst_osc : osc_sync;

  always_comb begin
    next_touch_out = touch_port_data_latch;
    next_touch_oe_n = float_now ? 8'hff : ~touch_port_direction;
    next_osc_oe_n = float_now ? {gpt_osc_w{1'b1}} : ~osc_port_direction;
    // open-drain pin releases rather than drives high
    next_osc_oe_n = next_osc_oe_n | (gpt_osc_open_drain & osc_port_data_latch);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_pin_out <= gpt_rst_byte;
      touch_pin_oe_n <= 8'hff;
    end else begin
      touch_pin_out <= next_touch_out;
      touch_pin_oe_n <= next_touch_oe_n;
    end
  end

  // pull-up dropped on any pin driving low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_pullup_on <= gpt_rst_byte;
    end else begin
      touch_pullup_on <= touch_port_pullup_enable & ~(~next_touch_oe_n & ~next_touch_out);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_port_in_en <= gpt_rst_byte;
      touch_sense_en <= gpt_rst_byte;
    end else begin
      touch_port_in_en <= touch_input_disable_upper & ~touch_in_blocked;
      touch_sense_en <= ~touch_input_disable_upper & ~touch_in_blocked;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_pin_out <= gpt_rst_osc;
      osc_pin_oe_n <= {gpt_osc_w{1'b1}};
    end else begin
      osc_pin_out <= osc_port_data_latch;
      osc_pin_oe_n <= next_osc_oe_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_pin_in_dummy_unused_n <= {gpt_osc_w{1'b1}};
    end else begin
      osc_pin_in_dummy_unused_n <= ~osc_pin_view;
    end
  end

  // read path
  always_comb begin
    rd_hit = 1'b1;
    next_rdata = '0;
    case (s_axi_araddr)
      gpt_off_touch_data: begin
        // output pins and modify reads see the latch
        next_rdata[7:0] = read_modify_write ? touch_port_data_latch :
          (touch_port_direction & touch_port_data_latch) | (~touch_port_direction & touch_pin_view);
      end
      gpt_off_touch_dir: next_rdata[7:0] = touch_port_direction;
      gpt_off_touch_pull: next_rdata[7:0] = touch_port_pullup_enable;
      gpt_off_touch_dis: next_rdata[7:0] = touch_input_disable_upper;
      gpt_off_osc_data: begin
        next_rdata[gpt_osc_w-1:0] = read_modify_write ? osc_port_data_latch :
          (osc_port_direction & osc_port_data_latch) | (~osc_port_direction & osc_pin_view);
      end
      gpt_off_osc_dir: next_rdata[gpt_osc_w-1:0] = osc_port_direction;
      gpt_off_standby: begin
        next_rdata[gpt_stby_float_bit] = standby_pin_float;
        next_rdata[gpt_stby_touch_run_bit] = touch_run_in_stop;
      end
      gpt_off_status: next_rdata[0] = float_now;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= gpt_resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_hit ? gpt_resp_okay : gpt_resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: test/gpt_port_checker.sv */
/*
 checker for gpt_port: bus handshakes and pin output relations.
 assumes only the top ports are visible; attached by the bind below.
*/
`timescale 1ns/1ns
module gpt_port_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] touch_pin_out,
  input wire logic [7:0] touch_pin_oe_n,
  input wire logic [7:0] touch_pullup_on,
  input wire logic [7:0] touch_port_in_en,
  input wire logic [7:0] touch_sense_en,
  input wire logic [2:0] osc_pin_out,
  input wire logic [2:0] osc_pin_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_pull_cut_low: assert property (!(|(touch_pullup_on & ~touch_pin_oe_n & ~touch_pin_out)))
    else $error("pull-up on a pin driving low");
  chk_paths_exclusive: assert property (!(|(touch_port_in_en & touch_sense_en)))
    else $error("port and touch input both enabled");
  chk_open_drain_high: assert property (!osc_pin_oe_n[2] |-> !osc_pin_out[2])
    else $error("open-drain pin driven high");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (|touch_pullup_on);
endmodule
bind gpt_port gpt_port_checker u_gpt_port_checker (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .touch_pin_out, .touch_pin_oe_n, .touch_pullup_on, .touch_port_in_en,
  .touch_sense_en, .osc_pin_out, .osc_pin_oe_n);

/* File: test/gpt_pins.sv */
/*
 pin-side model: a pin follows the port while enabled, else an outside source.
 assumes output enables are active low.
*/
`timescale 1ns/1ns
module gpt_pins (
  input wire logic [7:0] t_out,
  input wire logic [7:0] t_oe_n,
  input wire logic [7:0] t_ext,
  input wire logic [2:0] o_out,
  input wire logic [2:0] o_oe_n,
  input wire logic [2:0] o_ext,
  output logic [7:0] t_pin,
  output logic [2:0] o_pin
);
  // no other peripheral drives these pins
  assign t_pin = (t_out & ~t_oe_n) | (t_ext & t_oe_n);
  assign o_pin = (o_out & ~o_oe_n) | (o_ext & o_oe_n);
endmodule

/* File: test/tb.sv */
/*
 testbench for gpt_port: axi4-lite master, pin model, queued read checks.
 assumes the checker is bound and pins settle within four clocks.
*/
`timescale 1ns/1ns
module tb import gpt_pkg::*;;
  logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, read_modify_write, s_axi_arready, s_axi_rvalid, s_axi_rready, standby_enter;
  logic [gpt_aw-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_want;
  logic [7:0] touch_pin_in, touch_pin_out, touch_pin_oe_n, touch_pullup_on, touch_port_in_en, touch_sense_en, t_ext;
  logic [2:0] osc_pin_in, osc_pin_out, osc_pin_oe_n, o_ext, osc_view_n;
  logic [33:0] exp_q[$];
  int failures, comparisons, seed = 81561;
  gpt_port u_gpt_port (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .read_modify_write, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby_enter,
    .touch_pin_in, .touch_pin_out, .touch_pin_oe_n, .touch_pullup_on, .touch_port_in_en, .touch_sense_en,
    .osc_pin_in_dummy_unused_n(osc_view_n), .osc_pin_in, .osc_pin_out, .osc_pin_oe_n);
  gpt_pins u_gpt_pins (.t_out(touch_pin_out), .t_oe_n(touch_pin_oe_n), .t_ext(t_ext), .o_out(osc_pin_out),
    .o_oe_n(osc_pin_oe_n), .o_ext(o_ext), .t_pin(touch_pin_in), .o_pin(osc_pin_in));
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [gpt_aw-1:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    exp_q.push_back({resp_want, 32'h0});
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 64) begin failures++; final_report(); end
  endtask
  task automatic rd(input logic [gpt_aw-1:0] a, input logic m, input logic [31:0] want);
    int n;
    @(posedge clk);
    exp_q.push_back({resp_want, want});
    s_axi_araddr <= a; read_modify_write <= m; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 64) begin failures++; final_report(); end
  endtask
  task automatic pins(input logic [7:0] o, input logic [7:0] oe);
    repeat (4) @(posedge clk);
    chk(34'(touch_pin_out), 34'(o));
    chk(34'(touch_pin_oe_n), 34'(oe));
  endtask
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, read_modify_write} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, standby_enter, t_ext, o_ext} = '0;
    s_axi_wstrb = 4'hf;
    resp_want = gpt_resp_okay;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 1'b0, 32'h0);
    pins(8'h00, 8'hff);
    resp_want = gpt_resp_slverr;
    wr(5'h01, 32'hff);
    rd(5'h02, 1'b0, 32'h0);
    resp_want = gpt_resp_okay;
    $display("test reset done");
    d = $random(seed);
    t_ext <= ~d[7:0];
    wr(gpt_off_touch_dir, 32'hff);
    wr(gpt_off_touch_data, d);
    pins(d[7:0], 8'h00);
    rd(gpt_off_touch_data, 1'b0, {24'h0, d[7:0]});
    $display("test output done");
    e = $random(seed);
    t_ext <= e[7:0];
    wr(gpt_off_touch_dir, 32'h0f);
    wr(gpt_off_touch_dis, 32'h3c);
    wr(gpt_off_touch_data, ~d);
    pins(~d[7:0], 8'hf0);
    rd(gpt_off_touch_data, 1'b0, {24'h0, (~d[7:0] & 8'h0f) | (e[7:0] & 8'h30)});
    rd(gpt_off_touch_data, 1'b1, {24'h0, ~d[7:0]});
    $display("test input done");
    wr(gpt_off_touch_pull, 32'hff);
    wr(gpt_off_touch_dir, 32'hff);
    wr(gpt_off_touch_data, 32'ha5);
    pins(8'ha5, 8'h00);
    chk(34'(touch_pullup_on), 34'ha5);
    wr(gpt_off_touch_dir, 32'h00);
    pins(8'ha5, 8'hff);
    chk(34'(touch_pullup_on), 34'hff);
    $display("test pullup done");
    o_ext <= 3'h2;
    wr(gpt_off_osc_dir, 32'hff);
    wr(gpt_off_osc_data, 32'hff);
    repeat (4) @(posedge clk);
    chk(34'(osc_pin_oe_n), 34'h4);
    rd(gpt_off_osc_data, 1'b1, 32'h7);
    wr(gpt_off_osc_data, 32'h3);
    repeat (4) @(posedge clk);
    chk(34'({osc_pin_oe_n, osc_pin_out}), 34'h03);
    wr(gpt_off_osc_dir, 32'h0);
    repeat (4) @(posedge clk);
    rd(gpt_off_osc_data, 1'b0, 32'h2);
    chk(34'(osc_view_n), 34'h5);
    $display("test osc done");
    wr(gpt_off_touch_dir, 32'hff);
    standby_enter <= 1'b1;
    pins(8'ha5, 8'h00);
    wr(gpt_off_standby, 32'h1);
    pins(8'ha5, 8'hff);
    chk(34'({touch_port_in_en, touch_sense_en, osc_pin_oe_n}), 34'h7);
    rd(gpt_off_status, 1'b0, 32'h1);
    wr(gpt_off_standby, 32'h3);
    repeat (4) @(posedge clk);
    chk(34'({touch_port_in_en, touch_sense_en}), 34'h3cc3);
    standby_enter <= 1'b0;
    pins(8'ha5, 8'h00);
    $display("test standby done");
    wr(gpt_off_touch_pull, 32'h0);
    wr(gpt_off_touch_dir, 32'h0);
    wr(gpt_off_touch_dis, 32'h0);
    pins(8'ha5, 8'hff);
    chk(34'({touch_sense_en, touch_port_in_en, touch_pullup_on}), 34'hff0000);
    $display("test touch done");
    final_report();
  end
endmodule
